// File: hss_pkg.sv
// Purpose: Shared constants and types for the hub strap sampler.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes: Every offset, field position and reset value lives here.
package hss_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] HSS_REG_STATUS = 8'h00;    // Captured straps, live state
  localparam logic [7:0] HSS_REG_CONTROL = 8'h04;   // Power and LED requests
  localparam logic [7:0] HSS_REG_DOWNLOAD = 8'h08;  // Downloaded configuration
  localparam logic [7:0] HSS_REG_IRQ_STAT = 8'h0c;  // Sticky events, cleared by read
  localparam logic [7:0] HSS_REG_IRQ_MASK = 8'h10;  // Interrupt enables

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HSS_ST_METHOD = 0;       // [1:0] configuration method
  localparam int HSS_ST_FIXED_CODE = 2;   // [3:2] captured fixed-device code
  localparam int HSS_ST_PORT_OFF = 4;     // Captured port-off strap
  localparam int HSS_ST_GANG = 5;         // Captured gang strap
  localparam int HSS_ST_POWER_POL = 6;    // Latched power polarity
  localparam int HSS_ST_EFF_FIXED = 7;    // [9:7] effective non-removable mask
  localparam int HSS_ST_EFF_OFF = 10;     // Effective port 3 disable
  localparam int HSS_ST_EFF_GANG = 11;    // Effective ganged mode
  localparam int HSS_ST_RUN = 12;         // Straps captured, block running
  localparam int HSS_ST_POWER_ON = 13;    // [15:13] power granted per port
  localparam int HSS_ST_OC = 16;          // [18:16] over-current live per port
  localparam int HSS_CT_POWER = 0;        // [2:0] power request per port
  localparam int HSS_CT_LED = 3;          // [5:3] LED request per port
  localparam int HSS_DL_FIXED = 0;        // [1:0] downloaded fixed-device code
  localparam int HSS_DL_PORT_OFF = 2;     // Downloaded port 3 disable
  localparam int HSS_DL_GANG = 3;         // Downloaded ganged mode
  localparam int HSS_DL_LED_EN = 4;       // Downloaded LED support enable

  // ---------------------------------------------------------------
  // Sizes, reset values and timing counts
  // ---------------------------------------------------------------
  localparam int HSS_PORTS = 3;           // Downstream ports
  localparam int HSS_EVENTS = 4;          // Bit 0 capture done, bits 3:1 over-current
  localparam int HSS_SYNC_IN = 10;        // Pins passing the synchroniser
  localparam logic [1:0] HSS_SETTLE_EDGES = 2'h2;  // Edges for synchroniser to fill
  localparam logic [2:0] HSS_PORTS_RST = 3'h0;     // Requests off after reset
  localparam logic [2:0] HSS_OC_PREV_RST = 3'h7;   // No false onset after reset
  localparam logic [3:0] HSS_IRQ_RST = 4'h0;       // Status and mask reset
  localparam logic [31:0] HSS_RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HSS_METHOD_SMBUS = 2'b00,    // Slave download over the serial port
    HSS_METHOD_DEFAULT = 2'b01,  // Internal default, straps apply
    HSS_METHOD_EEPROM = 2'b10    // Load from serial EEPROM
  } hss_method_t;

  typedef enum logic [1:0] {
    HSS_ST_SETTLE = 2'b00,       // Waiting for synchronised straps
    HSS_ST_ACTIVE = 2'b01        // Straps held until next reset
  } hss_state_t;

endpackage

// File: hss_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes: First stage is read only by the second stage.
module hss_sync
  import hss_pkg::*;
#(
  parameter int WIDTH = HSS_SYNC_IN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;  // Metastable capture
    logic [WIDTH-1:0] stage2;  // Resolved value
  } hss_sync_t;

  hss_sync_t cur;
  hss_sync_t next_cur;

  // Shift the pin value through two stages
  always_comb begin
    next_cur = cur;
    next_cur.stage1 = async_in;
    next_cur.stage2 = cur.stage1;
  end

  // Register the copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.stage2;

endmodule

// File: hss_irq.sv
// Purpose: Sticky event status, mask and level interrupt.
// Assumes: Clear strobe comes from a status read on the same clock.
// Notes: A set in the clearing cycle survives the clear.
module hss_irq
  import hss_pkg::*;
#(
  parameter int N = HSS_EVENTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] event_set,
  input wire logic status_clear,
  input wire logic mask_write,
  input wire logic [N-1:0] mask_wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] status;  // Sticky event bits
    logic [N-1:0] mask;    // One enables the event onto irq
  } hss_irq_t;

  hss_irq_t cur;
  hss_irq_t next_cur;

  // Per-bit set and clear; the set term is applied last so it wins
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < N; i++) begin
      if (status_clear) begin
        next_cur.status[i] = 1'b0;
      end
      if (event_set[i]) begin
        next_cur.status[i] = 1'b1;
      end
    end
    if (mask_write) begin
      next_cur.mask = mask_wdata;
    end
  end

  // Register the copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign status = cur.status;
  assign mask = cur.mask;
  assign irq = |(cur.status & cur.mask);

endmodule

// File: hub_strap_sampler.sv
// Purpose: Reset-time strap capture and port power / LED polarity for a 3-port hub.
// Assumes: pclk 25 MHz; presetn is the hardware reset; straps are board resistors.
// Notes: LED pins double as straps, so they are never driven before capture.
//
// What this block does
// - Port-off strap one: port 3 off, LED low
// - Download LED support: port 1/2 LEDs active low
// - Default config samples fixed-device straps at release
// - Code 00: all removable, both LEDs high
// - Code 01: port 1 fixed, LED1 low
// - Code 10: ports 1,2 fixed, LED2 low
// - Code 11: ports 1-3 fixed, both LEDs low
// - Default config samples gang strap at release
// - Gang zero per-port, one ganged power/sensing
// - In reset, live polarity keeps power off
// - Latch power polarity at release until reset
// - Polarity one active high, zero active low
// - Low method select read at release
// - High method select combined at release
// - High 0 SMBus, 10 default, 11 EEPROM
// - Port-off strap zero: all enabled, LED high
// - Default config samples port-off strap at release
//
// The placing of the registers and the APB slave port were decided locally.
module hub_strap_sampler
  import hss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Shared LED / strap pins: bit 0 port 1, bit 1 port 2
  input wire logic [1:0] lower_port_leds_in,
  output logic [1:0] lower_port_leds_out,
  output logic [1:0] lower_port_leds_oe,
  // Port 3 LED shared with the port-off strap
  input wire logic third_port_led_in,
  output logic third_port_led_out,
  output logic third_port_led_oe,
  // Plain strap and sense inputs
  input wire logic gang_mode_strap,
  input wire logic power_level_strap,
  input wire logic config_method_low,
  input wire logic config_method_high,
  input wire logic [2:0] overcurrent_sense_in,
  // Port power switch enables
  output logic [2:0] port_power_enable
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Method from the two select straps
  function automatic hss_method_t method_of(input logic high, input logic low);
    if (!high) begin
      return HSS_METHOD_SMBUS;     // Low select is a don't-care
    end else if (!low) begin
      return HSS_METHOD_DEFAULT;
    end else begin
      return HSS_METHOD_EEPROM;
    end
  endfunction

  // Non-removable port mask from the fixed-device code
  function automatic logic [2:0] fixed_mask(input logic [1:0] code);
    case (code)
      2'b00: return 3'b000;        // All removable
      2'b01: return 3'b001;        // Port 1
      2'b10: return 3'b011;        // Ports 1 and 2
      2'b11: return 3'b111;        // Ports 1, 2 and 3
      default: return 3'b000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    hss_state_t state;        // Settle or active
    logic [1:0] settle_cnt;   // Edges since release
    hss_method_t method;      // Captured configuration method
    logic [1:0] fixed_code;   // Captured fixed-device code
    logic port_off;           // Captured port-off strap
    logic gang;               // Captured gang strap
    logic power_pol;          // Latched power polarity
    logic [2:0] power_req;    // Software power request
    logic [2:0] led_req;      // Software LED request
    logic [1:0] dl_fixed;     // Downloaded fixed-device code
    logic dl_port_off;        // Downloaded port 3 disable
    logic dl_gang;            // Downloaded ganged mode
    logic dl_led_en;          // Downloaded LED support
    logic [2:0] power_on;     // Granted power per port
    logic [2:0] power_pin;    // Power pin level after polarity
    logic [2:0] led_pin;      // LED pin level after polarity
    logic [2:0] led_oe;       // LED pin drive enable
    logic [2:0] oc_prev;      // Over-current seen last cycle
    logic [31:0] rdata;       // Read data held for the access phase
  } hss_top_t;

  hss_top_t cur;
  hss_top_t next_cur;

  logic [HSS_SYNC_IN-1:0] pins_async;   // Raw pins into the synchroniser
  logic [HSS_SYNC_IN-1:0] pins_sync;    // Same pins, two flops later
  logic [1:0] sync_lower_leds;          // Port 1/2 strap level
  logic sync_third_led;                 // Port-off strap level
  logic sync_gang;                      // Gang strap level
  logic sync_pol;                       // Polarity strap level
  logic sync_cfg_low;                   // Low method select level
  logic sync_cfg_high;                  // High method select level
  logic [2:0] oc_active;                // Over-current, active high
  logic is_default;                     // Straps govern configuration
  logic [1:0] eff_fixed;                // Effective fixed-device code
  logic eff_port_off;                   // Effective port 3 disable
  logic eff_gang;                       // Effective ganged mode
  logic [2:0] led_low;                  // LED active-low per port
  logic [2:0] led_drive;                // LEDs that may be driven
  logic [2:0] oc_block;                 // Ports blocked by over-current
  logic [2:0] want_on;                  // Power wanted before blocking
  logic [HSS_EVENTS-1:0] events;        // Pulses into the status register
  logic [HSS_EVENTS-1:0] irq_status;    // Sticky status
  logic [HSS_EVENTS-1:0] irq_mask;      // Mask
  logic setup;                          // APB setup phase
  logic access;                         // APB access phase
  logic addr_ok;                        // Address is mapped
  logic stat_clear;                     // Read of the sticky status
  logic mask_write;                     // Write of the mask

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Straps and sense lines come from the board, so all pass the synchroniser; only the pre-capture power output reads power_level_strap raw
  assign pins_async = {overcurrent_sense_in, config_method_high, config_method_low,
                       power_level_strap, gang_mode_strap, third_port_led_in,
                       lower_port_leds_in};

  hss_sync #(
    .WIDTH(HSS_SYNC_IN)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign sync_lower_leds = pins_sync[1:0];
  assign sync_third_led = pins_sync[2];
  assign sync_gang = pins_sync[3];
  assign sync_pol = pins_sync[4];
  assign sync_cfg_low = pins_sync[5];
  assign sync_cfg_high = pins_sync[6];
  // Sense lines rest high on the pull-up; low means over-current
  assign oc_active = ~pins_sync[9:7];

  // ---------------------------------------------------------------
  // Effective configuration
  // ---------------------------------------------------------------
  // Straps apply only under the internal default method
  always_comb begin
    is_default = (cur.method == HSS_METHOD_DEFAULT);
    if (is_default) begin
      eff_fixed = cur.fixed_code;
      eff_port_off = cur.port_off;
      eff_gang = cur.gang;
      // Port 1/2 LED polarity follows the fixed-device code bit for bit, port 3 the port-off strap
      led_low = {cur.port_off, cur.fixed_code};
      led_drive = 3'b111;
    end else begin
      eff_fixed = cur.dl_fixed;
      eff_port_off = cur.dl_port_off;
      eff_gang = cur.dl_gang;
      led_low = 3'b111;
      led_drive = {3{cur.dl_led_en}};        // Undriven without LED support
    end
  end

  // Over-current blocking: any port in ganged mode trips all ports
  always_comb begin
    if (eff_gang) begin
      oc_block = {3{|oc_active}};
      want_on = {3{cur.power_req[0]}};       // One switch for all ports
    end else begin
      oc_block = oc_active;
      want_on = cur.power_req;
    end
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign addr_ok = (paddr == HSS_REG_STATUS) || (paddr == HSS_REG_CONTROL) ||
                   (paddr == HSS_REG_DOWNLOAD) || (paddr == HSS_REG_IRQ_STAT) ||
                   (paddr == HSS_REG_IRQ_MASK);
  assign stat_clear = access && !pwrite && (paddr == HSS_REG_IRQ_STAT);
  assign mask_write = access && pwrite && (paddr == HSS_REG_IRQ_MASK);
  // Every access completes in one access cycle
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;

  // Capture and over-current onsets; unread bits survive the clear
  assign events = {oc_active & ~cur.oc_prev & {3{cur.state == HSS_ST_ACTIVE}},
                   (cur.state == HSS_ST_SETTLE) && (cur.settle_cnt == HSS_SETTLE_EDGES)};

  hss_irq #(
    .N(HSS_EVENTS)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(events | (irq_status & ~cur.rdata[HSS_EVENTS-1:0] & {HSS_EVENTS{stat_clear}})),
    .status_clear(stat_clear),
    .mask_write(mask_write),
    .mask_wdata(pwdata[HSS_EVENTS-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    case (cur.state)
      // Wait until the synchroniser holds the post-release pin levels
      HSS_ST_SETTLE: begin
        if (cur.settle_cnt == HSS_SETTLE_EDGES) begin
          next_cur.method = method_of(sync_cfg_high, sync_cfg_low);
          next_cur.fixed_code = sync_lower_leds;
          next_cur.port_off = sync_third_led;
          next_cur.gang = sync_gang;
          next_cur.power_pol = sync_pol;
          next_cur.power_pin = {3{~sync_pol}};  // Off until first update
          next_cur.state = HSS_ST_ACTIVE;
        end else begin
          next_cur.settle_cnt = cur.settle_cnt + 2'h1;
        end
      end
      // Captured values stay put until the next reset
      HSS_ST_ACTIVE: begin
        next_cur.oc_prev = oc_active;
        // Port 3 can never be powered while disabled
        next_cur.power_on = want_on & ~oc_block & {~eff_port_off, 2'b11};
        // Active-high polarity passes the level, active-low inverts it
        next_cur.power_pin = cur.power_pol ? next_cur.power_on
                                           : ~next_cur.power_on;
        // Disabled port 3 never lights
        next_cur.led_pin = (cur.led_req & {~eff_port_off, 2'b11}) ^ led_low;
        next_cur.led_oe = led_drive;
      end
      default: begin
        next_cur.state = HSS_ST_SETTLE;
      end
    endcase

    // Register writes take effect at the access edge
    if (access && pwrite) begin
      case (paddr)
        HSS_REG_CONTROL: begin
          next_cur.power_req = pwdata[HSS_CT_POWER +: 3];
          next_cur.led_req = pwdata[HSS_CT_LED +: 3];
        end
        HSS_REG_DOWNLOAD: begin
          next_cur.dl_fixed = pwdata[HSS_DL_FIXED +: 2];
          next_cur.dl_port_off = pwdata[HSS_DL_PORT_OFF];
          next_cur.dl_gang = pwdata[HSS_DL_GANG];
          next_cur.dl_led_en = pwdata[HSS_DL_LED_EN];
        end
        default: begin
        end
      endcase
    end

    // Read data is prepared in the setup cycle so prdata is a flop
    if (setup && !pwrite) begin
      next_cur.rdata = HSS_RDATA_RST;
      case (paddr)
        HSS_REG_STATUS: begin
          next_cur.rdata[HSS_ST_METHOD +: 2] = cur.method;
          next_cur.rdata[HSS_ST_FIXED_CODE +: 2] = cur.fixed_code;
          next_cur.rdata[HSS_ST_PORT_OFF] = cur.port_off;
          next_cur.rdata[HSS_ST_GANG] = cur.gang;
          next_cur.rdata[HSS_ST_POWER_POL] = cur.power_pol;
          next_cur.rdata[HSS_ST_EFF_FIXED +: 3] = fixed_mask(eff_fixed);
          next_cur.rdata[HSS_ST_EFF_OFF] = eff_port_off;
          next_cur.rdata[HSS_ST_EFF_GANG] = eff_gang;
          next_cur.rdata[HSS_ST_RUN] = (cur.state == HSS_ST_ACTIVE);
          next_cur.rdata[HSS_ST_POWER_ON +: 3] = cur.power_on;
          next_cur.rdata[HSS_ST_OC +: 3] = oc_active;
        end
        HSS_REG_CONTROL: begin
          next_cur.rdata[HSS_CT_POWER +: 3] = cur.power_req;
          next_cur.rdata[HSS_CT_LED +: 3] = cur.led_req;
        end
        HSS_REG_DOWNLOAD: begin
          next_cur.rdata[HSS_DL_FIXED +: 2] = cur.dl_fixed;
          next_cur.rdata[HSS_DL_PORT_OFF] = cur.dl_port_off;
          next_cur.rdata[HSS_DL_GANG] = cur.dl_gang;
          next_cur.rdata[HSS_DL_LED_EN] = cur.dl_led_en;
        end
        // Status sampled here; any later event stays for the next read
        HSS_REG_IRQ_STAT: next_cur.rdata[HSS_EVENTS-1:0] = irq_status;
        HSS_REG_IRQ_MASK: next_cur.rdata[HSS_EVENTS-1:0] = irq_mask;
        default: next_cur.rdata = HSS_RDATA_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset loads constants only; straps are taken after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.state <= HSS_ST_SETTLE;
      cur.method <= HSS_METHOD_SMBUS;
      cur.power_req <= HSS_PORTS_RST;
      cur.led_req <= HSS_PORTS_RST;
      cur.oc_prev <= HSS_OC_PREV_RST;
      cur.rdata <= HSS_RDATA_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Until capture the live strap sets the inactive level, so no port is powered;
  // combinational on purpose: no clock edge can be trusted during reset.
  assign port_power_enable = (!presetn || cur.state != HSS_ST_ACTIVE) ?
                             {3{~power_level_strap}} : cur.power_pin;

  // LED pins stay released while their levels are still straps
  assign lower_port_leds_out = cur.led_pin[1:0];
  assign lower_port_leds_oe = cur.led_oe[1:0];
  assign third_port_led_out = cur.led_pin[2];
  assign third_port_led_oe = cur.led_oe[2];
  assign prdata = cur.rdata;

endmodule

// File: hss_board.sv
// Purpose: Board model: strap resistors, LED loads and current monitors.
// Assumes: Strap bits {cfg_hi, cfg_lo, gang, pol, port_off, code[1:0]}.
// Notes: A released LED pin falls back to its strap resistor level.
module hss_board (
  input wire logic [6:0] straps,
  input wire logic [2:0] oc_fault,
  input wire logic [2:0] led_out,
  input wire logic [2:0] led_oe,
  output logic [6:0] pins,
  output logic [2:0] ocs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared pins: the driver wins, else the resistor sets the level
  assign pins = {straps[6:3], (led_oe & led_out) | (~led_oe & straps[2:0])};
  // Monitor pulls low on a fault, pull-up holds it idle otherwise
  assign ocs_n = ~oc_fault;
endmodule

// File: hss_properties.sv
// Purpose: Port-level timing properties of the strap sampler.
// Assumes: Capture on the third edge after release, LEDs driven from edge 4 under the default method.
// Notes: Sees top-level ports only.
module hss_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_level_strap,
  input wire logic config_method_low,
  input wire logic config_method_high,
  input wire logic [1:0] lower_port_leds_oe,
  input wire logic [2:0] port_power_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Release of reset, then the strap capture edge
  sequence s_rel; $rose(presetn); endsequence
  sequence s_dflt; s_rel ##2 (config_method_high && !config_method_low); endsequence
  property p_pol;
    s_rel ##2 1'b1 |=> ##1 port_power_enable == {3{~$past(power_level_strap, 2)}};
  endproperty
  a_reset_power_off: assert property (disable iff (1'b0)
    !presetn |-> port_power_enable == {3{~power_level_strap}}) else $error("power on in reset");
  a_early_power_off: assert property (
    s_rel |-> (port_power_enable == {3{~power_level_strap}})[*4]) else $error("early power");
  a_leds_released: assert property (
    s_rel |-> (lower_port_leds_oe == 2'h0)[*3]) else $error("LED driven early");
  a_pol_latched: assert property (p_pol) else $error("polarity not latched");
  a_default_leds: assert property (
    s_dflt |-> ##2 lower_port_leds_oe == 2'h3) else $error("LEDs not driven");
  a_download_leds: assert property (
    s_rel ##2 !(config_method_high && !config_method_low) |-> ##2 lower_port_leds_oe == 2'h0)
    else $error("LEDs driven without support");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped");
  a_ok_mapped: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped");
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("wait state");
endmodule

bind hub_strap_sampler hss_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .power_level_strap(power_level_strap), .config_method_low(config_method_low),
  .config_method_high(config_method_high), .lower_port_leds_oe(lower_port_leds_oe),
  .port_power_enable(port_power_enable));

// File: hub_strap_sampler_test.sv
// Purpose: Self-checking bench for the strap sampler.
// Assumes: Zero-wait APB slave, capture three edges after release.
// Notes: Each strap set is applied under reset, then judged at the pins.
`define CHK(g, e, nm) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module hub_strap_sampler_test
  import hss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, t_out, t_oe, er;
  logic [1:0] lo_out, lo_oe;
  logic [2:0] pe, ocs_n, oc_fault = 3'h0;
  logic [6:0] pins, straps = 7'h40;
  int n_errors = 0, compares = 0;
  always #20 pclk = ~pclk;
  hss_board board_u (.straps(straps), .oc_fault(oc_fault), .led_out({t_out, lo_out}),
    .led_oe({t_oe, lo_oe}), .pins(pins), .ocs_n(ocs_n));
  hub_strap_sampler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lower_port_leds_in(pins[1:0]), .lower_port_leds_out(lo_out),
    .lower_port_leds_oe(lo_oe), .third_port_led_in(pins[2]), .third_port_led_out(t_out),
    .third_port_led_oe(t_oe), .gang_mode_strap(pins[4]), .power_level_strap(pins[3]),
    .config_method_low(pins[5]), .config_method_high(pins[6]),
    .overcurrent_sense_in(ocs_n), .port_power_enable(pe));
  task automatic summarize;
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // This task changes straps only under reset, so capture sees them settled
  task automatic rst(input logic [6:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    straps <= s;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic t_unmapped;
    apb(1'b1, 8'h14, 32'h3f);
    `CHK(er, 1'b1, "write err")
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0}, "read err")
    apb(1'b0, HSS_REG_CONTROL, 32'h0);
    `CHK({er, rd}, 33'h0, "control")
  endtask
  // Every fixed-device code, port-off, polarity and gang value in default mode
  task automatic t_straps;
    logic [2:0] m;
    logic [12:0] ex;
    for (int i = 0; i < 16; i++) begin
      rst({2'b10, i[1], i[3:0]});
      m = 3'((4'h1 << i[1:0]) - 4'h1);
      apb(1'b0, HSS_REG_STATUS, 32'h0);
      ex = {1'b1, i[1], i[2], m, i[3], i[1], i[2], i[1:0], 2'b01};
      `CHK(rd[12:0], ex, "status")
      `CHK({t_out, lo_out, pe}, {i[2], i[1:0], {3{~i[3]}}}, "idle")
      apb(1'b1, HSS_REG_CONTROL, 32'h3f);
      settle;
      `CHK({t_out, lo_out, pe}, {1'b1, ~i[1:0], {~i[2], 2'b11} ^ {3{~i[3]}}}, "lit")
    end
  endtask
  task automatic t_method;
    logic [1:0] mt;
    for (int j = 0; j < 4; j++) begin
      rst({j[1:0], 5'h17});
      mt = j[1] ? {j[0], ~j[0]} : 2'b00;
      apb(1'b0, HSS_REG_STATUS, 32'h0);
      `CHK({rd[11:7], t_oe, lo_oe, rd[1:0]}, {{8{mt[0]}}, mt}, "method")
      apb(1'b1, HSS_REG_DOWNLOAD, 32'h1f);
      apb(1'b0, HSS_REG_STATUS, 32'h0);
      settle;
      `CHK({rd[11:7], t_oe, lo_oe, lo_out, rd[1:0]}, {10'h3ff, mt}, "download")
    end
  endtask
  // Per-port and ganged power, polarity held after the pin flips, fault event
  task automatic t_power;
    for (int g = 0; g < 2; g++) begin
      rst({2'b10, g[0], ~g[0], 3'h0});
      apb(1'b0, HSS_REG_IRQ_STAT, 32'h0);
      `CHK(rd[0], 1'b1, "capture event")
      apb(1'b1, HSS_REG_IRQ_MASK, 32'he);
      apb(1'b1, HSS_REG_CONTROL, 32'h3);
      straps[3] <= g[0];
      settle;
      `CHK(pe, (g[0] ? 3'h7 : 3'h3) ^ {3{g[0]}}, "power on")
      oc_fault <= 3'h2;
      repeat (4) @(posedge pclk);
      settle;
      `CHK({irq, pe}, {1'b1, (g[0] ? 3'h0 : 3'h1) ^ {3{g[0]}}}, "fault")
      apb(1'b0, HSS_REG_IRQ_STAT, 32'h0);
      settle;
      `CHK({irq, |rd[3:1]}, 2'b01, "irq clear")
      oc_fault <= 3'h0;
    end
  endtask
  initial begin
    rst(7'h40);
    t_unmapped();
    t_straps();
    t_method();
    t_power();
    summarize();
  end
endmodule
